// ==== common/tcod_pkg.sv ====
/*
 Constants of the thermocouple channel object dictionary: object indices,
 subindices, status image layout, reset values and compensation modes.
 Assumes a four-channel slave whose channel objects repeat every 16 indices.
*/
`default_nettype none
package tcod_pkg;
   // Channel layout
   localparam int          TCOD_CHANNELS      = 4;
   localparam logic [15:0] TCOD_SPACING       = 16'h0010;
   localparam logic [15:0] TCOD_COUNT         = 16'h0004;
   localparam logic [15:0] TCOD_COMM_PROFILE  = 16'h1389;
   // Channel object groups, index bits 15..8, with low nibble
   localparam logic [7:0]  TCOD_GRP_INPUTS    = 8'h60;
   localparam logic [7:0]  TCOD_GRP_OUTPUTS   = 8'h70;
   localparam logic [7:0]  TCOD_GRP_CONFIG    = 8'h80;
   localparam logic [3:0]  TCOD_LO_BASE       = 4'h0;
   localparam logic [3:0]  TCOD_LO_INTERNAL   = 4'hE;
   // Device-wide indices
   localparam logic [15:0] TCOD_IDX_DEV_TYPE  = 16'h1000;
   localparam logic [15:0] TCOD_IDX_IDENTITY  = 16'h1018;
   localparam logic [15:0] TCOD_IDX_BACKUP    = 16'h10F0;
   localparam logic [15:0] TCOD_IDX_PROFILE   = 16'hF000;
   localparam logic [15:0] TCOD_IDX_CODE_WORD = 16'hF008;
   // Subindices
   localparam logic [7:0]  TCOD_SUB_MAX       = 8'h00;
   localparam logic [7:0]  TCOD_SUB_BELOW     = 8'h01;
   localparam logic [7:0]  TCOD_SUB_ABOVE     = 8'h02;
   localparam logic [7:0]  TCOD_SUB_LIMIT1    = 8'h03;
   localparam logic [7:0]  TCOD_SUB_LIMIT2    = 8'h05;
   localparam logic [7:0]  TCOD_SUB_INVALID   = 8'h07;
   localparam logic [7:0]  TCOD_SUB_VALIDITY  = 8'h0F;
   localparam logic [7:0]  TCOD_SUB_TOGGLE    = 8'h10;
   localparam logic [7:0]  TCOD_SUB_VALUE     = 8'h11;
   localparam logic [7:0]  TCOD_SUB_EN_LIM1   = 8'h07;
   localparam logic [7:0]  TCOD_SUB_EN_LIM2   = 8'h08;
   localparam logic [7:0]  TCOD_SUB_JMODE     = 8'h0C;
   localparam logic [7:0]  TCOD_SUB_THR1      = 8'h13;
   localparam logic [7:0]  TCOD_SUB_THR2      = 8'h14;
   localparam logic [7:0]  TCOD_SUB_RAW_TC    = 8'h01;
   localparam logic [7:0]  TCOD_SUB_RAW_REF   = 8'h02;
   localparam logic [7:0]  TCOD_SUB_J_TEMP    = 8'h03;
   localparam logic [7:0]  TCOD_SUB_J_VOLT    = 8'h04;
   localparam logic [7:0]  TCOD_SUB_J_RES     = 8'h05;
   localparam logic [7:0]  TCOD_SUB_MAKER     = 8'h01;
   localparam logic [7:0]  TCOD_SUB_PRODUCT   = 8'h02;
   localparam logic [7:0]  TCOD_SUB_REVISION  = 8'h03;
   localparam logic [7:0]  TCOD_SUB_SERIAL    = 8'h04;
   localparam logic [7:0]  TCOD_SUB_CHECKSUM  = 8'h01;
   localparam logic [7:0]  TCOD_SUB_SPACING   = 8'h01;
   localparam logic [7:0]  TCOD_SUB_COUNT     = 8'h02;
   // Maximum subindex values
   localparam logic [7:0]  TCOD_MAX_INPUTS    = 8'h11;
   localparam logic [7:0]  TCOD_MAX_OUTPUTS   = 8'h11;
   localparam logic [7:0]  TCOD_MAX_INTERNAL  = 8'h05;
   localparam logic [7:0]  TCOD_MAX_IDENTITY  = 8'h04;
   localparam logic [7:0]  TCOD_MAX_BACKUP    = 8'h01;
   localparam logic [7:0]  TCOD_MAX_PROFILE   = 8'h02;
   // Status image bit positions
   localparam int          TCOD_BIT_BELOW     = 0;
   localparam int          TCOD_BIT_ABOVE     = 1;
   localparam int          TCOD_BIT_LIM1      = 2;
   localparam int          TCOD_BIT_LIM2      = 4;
   localparam int          TCOD_BIT_INVALID   = 6;
   localparam int          TCOD_BIT_VALIDITY  = 14;
   localparam int          TCOD_BIT_TOGGLE    = 15;
   // Limit codes and saturation
   localparam logic [1:0]  TCOD_LIM_OFF       = 2'h0;
   localparam logic [1:0]  TCOD_LIM_ABOVE     = 2'h1;
   localparam logic [1:0]  TCOD_LIM_BELOW     = 2'h2;
   localparam logic [1:0]  TCOD_LIM_ILLEGAL   = 2'h3;
   localparam logic [15:0] TCOD_SAT_MAX       = 16'h7FFF;
   localparam logic [15:0] TCOD_SAT_MIN       = 16'h8000;
   // Reset values
   localparam logic [15:0] TCOD_RST_WORD16    = 16'h0000;
   localparam logic [31:0] TCOD_RST_WORD32    = 32'h0000_0000;
   // Cold junction compensation source
   typedef enum logic [1:0] {
      TCOD_JMODE_INTERNAL = 2'b00,
      TCOD_JMODE_NONE     = 2'b01,
      TCOD_JMODE_EXTERNAL = 2'b10
   } tcod_jmode_t;
endpackage : tcod_pkg
`default_nettype wire

// ==== rtl/tcod_object_dictionary.sv ====
/*
 Object dictionary of a four-channel thermocouple input slave: status image,
 compensated value, external junction temperature, diagnostics, identity.
 Assumes the measurement chain and the object access engine run on sys_clk.
*/
// Notes on behaviour
// - Below-range flag follows the measured input lying under the measuring range.
// - Above-range flag on range exceeded; with invalid flag it means open wire.
// - Two 2-bit limit fields: 0 inactive, 1 above limit, 2 below limit.
// - Invalid flag set on open wire, above range or below range.
// - Validity flag reads 0 for valid data and 1 for invalid data.
// - Update toggle inverts on every refresh of a channel's input data.
// - Measured value is signed 16-bit, read-only, reset to zero.
// - Master supplies signed junction temperature in 0.1 degree; used when chosen.
// - Raw thermocouple and reference sensor conversions readable as unsigned 32-bit.
// - Junction temperature, voltage and resistance diagnostics readable per channel.
// - Report channel spacing of 16 and four channels; channel at base plus 16n.
// - Device type: profile 5001 in low half, module profile in high half.
// - Revision: variant number in bits 0-15, description revision in 16-31.
// - Serial: year in bits 0-7, week in 8-15, zero above.
// - Read-only maker identification with product code and revision.
// - Read-only checksum over all backup parameter entries.
// - Limit fields compare against two signed 16-bit thresholds per channel.
// - Junction mode selects internal (0), none (1) or master data (2).
`default_nettype none
module tcod_object_dictionary
   import tcod_pkg::*;
#(
   parameter logic [31:0] MAKER_ID       = 32'h0000_5A17, // Arbitrary value
   parameter logic [31:0] PRODUCT_ID     = 32'h0000_0001, // Arbitrary value
   parameter logic [15:0] VARIANT_NUM    = 16'h0000,
   parameter logic [15:0] DESC_REVISION  = 16'h0001,
   parameter logic [15:0] MODULE_PROFILE = 16'h0000,
   parameter logic [7:0]  PROD_YEAR      = 8'h00,
   parameter logic [7:0]  PROD_WEEK      = 8'h00
) (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  nrst,
   // Object access
   input  wire logic                  obj_rd,
   input  wire logic                  obj_wr,
   input  wire logic [15:0]           obj_index,
   input  wire logic [7:0]            obj_subindex,
   input  wire logic [31:0]           obj_wdata,
   output var  logic [31:0]           obj_rdata,
   output var  logic                  obj_ack,
   output var  logic                  obj_err,
   // Samples from the measurement chain
   input  wire logic                  smp_valid,
   input  wire logic [1:0]            smp_chan,
   input  wire logic [15:0]           smp_rel_temp,
   input  wire logic                  smp_below,
   input  wire logic                  smp_above,
   input  wire logic                  smp_open,
   input  wire logic [31:0]           smp_raw_couple,
   input  wire logic [31:0]           smp_raw_ref,
   input  wire logic [15:0]           smp_junction_temp,
   input  wire logic [15:0]           smp_junction_volt,
   input  wire logic [15:0]           smp_junction_res,
   // Cyclic input image
   output var  logic [3:0][15:0]      pd_status,
   output var  logic [3:0][15:0]      pd_value
);

   // Stored configuration and diagnostics
   logic [3:0][15:0] thr1_q;
   logic [3:0][15:0] thr2_q;
   logic [3:0]       en_lim1_q;
   logic [3:0]       en_lim2_q;
   tcod_jmode_t      jmode_q [TCOD_CHANNELS];
   logic [3:0][15:0] ext_temp_q;
   logic [3:0][31:0] raw_couple_q;
   logic [3:0][31:0] raw_ref_q;
   logic [3:0][15:0] j_temp_q;
   logic [3:0][15:0] j_volt_q;
   logic [3:0][15:0] j_res_q;
   logic [31:0]      code_word_q;
   logic [31:0]      checksum_q;
   logic [31:0]      checksum_d;

   // Address decode
   wire logic [7:0]  idx_grp    = obj_index[15:8];
   wire logic [3:0]  idx_lo     = obj_index[3:0];
   wire logic [1:0]  ch         = obj_index[5:4];
   wire logic        ch_ok      = (obj_index[7:6] == 2'b00);
   wire logic        hit_in     = ch_ok && idx_grp == TCOD_GRP_INPUTS && idx_lo == TCOD_LO_BASE;
   wire logic        hit_out    = ch_ok && idx_grp == TCOD_GRP_OUTPUTS && idx_lo == TCOD_LO_BASE;
   wire logic        hit_cfg    = ch_ok && idx_grp == TCOD_GRP_CONFIG && idx_lo == TCOD_LO_BASE;
   wire logic        hit_int    = ch_ok && idx_grp == TCOD_GRP_CONFIG && idx_lo == TCOD_LO_INTERNAL;
   wire logic        wr_only    = obj_wr && !obj_rd;
   wire logic        rd_only    = obj_rd && !obj_wr;
   wire logic        wr_ext     = wr_only && hit_out && obj_subindex == TCOD_SUB_VALUE;
   wire logic        wr_thr1    = wr_only && hit_cfg && obj_subindex == TCOD_SUB_THR1;
   wire logic        wr_thr2    = wr_only && hit_cfg && obj_subindex == TCOD_SUB_THR2;
   wire logic        wr_en1     = wr_only && hit_cfg && obj_subindex == TCOD_SUB_EN_LIM1;
   wire logic        wr_en2     = wr_only && hit_cfg && obj_subindex == TCOD_SUB_EN_LIM2;
   // only the three documented codes are accepted
   wire logic        wr_jmode   = wr_only && hit_cfg && obj_subindex == TCOD_SUB_JMODE
                                  && obj_wdata[1:0] != TCOD_LIM_ILLEGAL;
   wire logic        wr_code    = wr_only && obj_index == TCOD_IDX_CODE_WORD && obj_subindex == TCOD_SUB_MAX;
   wire logic        wr_ok      = wr_ext || wr_thr1 || wr_thr2 || wr_en1 || wr_en2 || wr_jmode || wr_code;

   // Sample processing for the addressed channel
   wire logic [15:0] thr1_s     = thr1_q[smp_chan];
   wire logic [15:0] thr2_s     = thr2_q[smp_chan];
   tcod_jmode_t      jmode_s;
   logic [15:0]      junc_sel;
   logic [16:0]      sum_ext;
   logic [15:0]      value_d;
   logic [15:0]      status_d;
   wire logic        above_d    = smp_above || smp_open;
   // invalid on open wire, above or below range
   wire logic        invalid_d  = smp_open || smp_above || smp_below;

   function automatic logic [1:0] limit_state(input logic en, input logic [15:0] val, input logic [15:0] thr);
      logic [1:0] res;
      res = TCOD_LIM_OFF;
      if (en && $signed(val) > $signed(thr)) begin
         res = TCOD_LIM_ABOVE;
      end else if (en && $signed(val) < $signed(thr)) begin
         res = TCOD_LIM_BELOW;
      end
      return res;
   endfunction

   always_comb begin
      jmode_s = jmode_q[smp_chan];
      unique case (jmode_s)
         TCOD_JMODE_INTERNAL: junc_sel = smp_junction_temp;
         TCOD_JMODE_NONE:     junc_sel = TCOD_RST_WORD16;
         TCOD_JMODE_EXTERNAL: junc_sel = ext_temp_q[smp_chan];
         default:             junc_sel = TCOD_RST_WORD16;
      endcase
      sum_ext = {smp_rel_temp[15], smp_rel_temp} + {junc_sel[15], junc_sel};
      // signed value, saturated to 16 bits
      if (sum_ext[16] != sum_ext[15]) begin
         value_d = sum_ext[16] ? TCOD_SAT_MIN : TCOD_SAT_MAX;
      end else begin
         value_d = sum_ext[15:0];
      end
      status_d = TCOD_RST_WORD16;
      status_d[TCOD_BIT_BELOW] = smp_below;
      // above range, also forced by open wire
      status_d[TCOD_BIT_ABOVE] = above_d;
      status_d[TCOD_BIT_LIM1 +: 2] = limit_state(en_lim1_q[smp_chan], value_d, thr1_s);
      status_d[TCOD_BIT_LIM2 +: 2] = limit_state(en_lim2_q[smp_chan], value_d, thr2_s);
      status_d[TCOD_BIT_INVALID] = invalid_d;
      status_d[TCOD_BIT_VALIDITY] = invalid_d;
      status_d[TCOD_BIT_TOGGLE] = ~pd_status[smp_chan][TCOD_BIT_TOGGLE];
   end

   always_comb begin
      checksum_d = TCOD_RST_WORD32;
      for (int k = 0; k < TCOD_CHANNELS; k++) begin
         checksum_d = checksum_d + {16'h0000, thr1_q[k]} + {16'h0000, thr2_q[k]}
                      + {30'h0000_0000, jmode_q[k]} + {31'h0000_0000, en_lim1_q[k]}
                      + {31'h0000_0000, en_lim2_q[k]};
      end
   end

   // Read multiplexer
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb begin
      rd_val = TCOD_RST_WORD32;
      rd_ok  = 1'b1;
      if (hit_in) begin
         unique case (obj_subindex)
            TCOD_SUB_MAX:      rd_val[7:0] = TCOD_MAX_INPUTS;
            TCOD_SUB_BELOW:    rd_val[0] = pd_status[ch][TCOD_BIT_BELOW];
            TCOD_SUB_ABOVE:    rd_val[0] = pd_status[ch][TCOD_BIT_ABOVE];
            TCOD_SUB_LIMIT1:   rd_val[1:0] = pd_status[ch][TCOD_BIT_LIM1 +: 2];
            TCOD_SUB_LIMIT2:   rd_val[1:0] = pd_status[ch][TCOD_BIT_LIM2 +: 2];
            TCOD_SUB_INVALID:  rd_val[0] = pd_status[ch][TCOD_BIT_INVALID];
            TCOD_SUB_VALIDITY: rd_val[0] = pd_status[ch][TCOD_BIT_VALIDITY];
            TCOD_SUB_TOGGLE:   rd_val[0] = pd_status[ch][TCOD_BIT_TOGGLE];
            TCOD_SUB_VALUE:    rd_val[15:0] = pd_value[ch];
            default:           rd_ok = 1'b0;
         endcase
      end else if (hit_out) begin
         unique case (obj_subindex)
            TCOD_SUB_MAX:      rd_val[7:0] = TCOD_MAX_OUTPUTS;
            TCOD_SUB_VALUE:    rd_val[15:0] = ext_temp_q[ch];
            default:           rd_ok = 1'b0;
         endcase
      end else if (hit_cfg) begin
         unique case (obj_subindex)
            TCOD_SUB_EN_LIM1:  rd_val[0] = en_lim1_q[ch];
            TCOD_SUB_EN_LIM2:  rd_val[0] = en_lim2_q[ch];
            TCOD_SUB_JMODE:    rd_val[1:0] = jmode_q[ch];
            TCOD_SUB_THR1:     rd_val[15:0] = thr1_q[ch];
            TCOD_SUB_THR2:     rd_val[15:0] = thr2_q[ch];
            default:           rd_ok = 1'b0;
         endcase
      end else if (hit_int) begin
         unique case (obj_subindex)
            TCOD_SUB_MAX:      rd_val[7:0] = TCOD_MAX_INTERNAL;
            TCOD_SUB_RAW_TC:   rd_val = raw_couple_q[ch];
            TCOD_SUB_RAW_REF:  rd_val = raw_ref_q[ch];
            TCOD_SUB_J_TEMP:   rd_val[15:0] = j_temp_q[ch];
            TCOD_SUB_J_VOLT:   rd_val[15:0] = j_volt_q[ch];
            TCOD_SUB_J_RES:    rd_val[15:0] = j_res_q[ch];
            default:           rd_ok = 1'b0;
         endcase
      end else if (obj_index == TCOD_IDX_PROFILE) begin
         unique case (obj_subindex)
            TCOD_SUB_MAX:      rd_val[7:0] = TCOD_MAX_PROFILE;
            TCOD_SUB_SPACING:  rd_val[15:0] = TCOD_SPACING;
            TCOD_SUB_COUNT:    rd_val[15:0] = TCOD_COUNT;
            default:           rd_ok = 1'b0;
         endcase
      end else if (obj_index == TCOD_IDX_IDENTITY) begin
         unique case (obj_subindex)
            TCOD_SUB_MAX:      rd_val[7:0] = TCOD_MAX_IDENTITY;
            TCOD_SUB_MAKER:    rd_val = MAKER_ID;
            TCOD_SUB_PRODUCT:  rd_val = PRODUCT_ID;
            TCOD_SUB_REVISION: rd_val = {DESC_REVISION, VARIANT_NUM};
            TCOD_SUB_SERIAL:   rd_val = {16'h0000, PROD_WEEK, PROD_YEAR};
            default:           rd_ok = 1'b0;
         endcase
      end else if (obj_index == TCOD_IDX_BACKUP) begin
         unique case (obj_subindex)
            TCOD_SUB_MAX:      rd_val[7:0] = TCOD_MAX_BACKUP;
            TCOD_SUB_CHECKSUM: rd_val = checksum_q;
            default:           rd_ok = 1'b0;
         endcase
      end else if (obj_index == TCOD_IDX_DEV_TYPE && obj_subindex == TCOD_SUB_MAX) begin
         rd_val = {MODULE_PROFILE, TCOD_COMM_PROFILE};
      end else if (obj_index == TCOD_IDX_CODE_WORD && obj_subindex == TCOD_SUB_MAX) begin
         rd_val = code_word_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Access answer one cycle after the request
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         obj_ack   <= 1'b0;
         obj_err   <= 1'b0;
         obj_rdata <= TCOD_RST_WORD32;
      end else begin
         obj_ack   <= obj_rd || obj_wr;
         obj_err   <= (obj_rd && obj_wr) || (rd_only && !rd_ok) || (wr_only && !wr_ok);
         obj_rdata <= (rd_only && rd_ok) ? rd_val : TCOD_RST_WORD32;
      end
   end

   // Writable objects
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         thr1_q      <= '0;
         thr2_q      <= '0;
         en_lim1_q   <= '0;
         en_lim2_q   <= '0;
         ext_temp_q  <= '0;
         code_word_q <= TCOD_RST_WORD32;
         checksum_q  <= TCOD_RST_WORD32;
         for (int k = 0; k < TCOD_CHANNELS; k++) begin
            jmode_q[k] <= TCOD_JMODE_INTERNAL;
         end
      end else begin
         checksum_q <= checksum_d;
         if (wr_code) begin
            code_word_q <= obj_wdata;
         end
         if (wr_ext) begin
            ext_temp_q[ch] <= obj_wdata[15:0];
         end
         if (wr_thr1) begin
            thr1_q[ch] <= obj_wdata[15:0];
         end
         if (wr_thr2) begin
            thr2_q[ch] <= obj_wdata[15:0];
         end
         if (wr_en1) begin
            en_lim1_q[ch] <= obj_wdata[0];
         end
         if (wr_en2) begin
            en_lim2_q[ch] <= obj_wdata[0];
         end
         if (wr_jmode) begin
            jmode_q[ch] <= tcod_jmode_t'(obj_wdata[1:0]);
         end
      end
   end

   // whole channel image refreshed in one edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pd_status    <= '0;
         pd_value     <= '0;
         raw_couple_q <= '0;
         raw_ref_q    <= '0;
         j_temp_q     <= '0;
         j_volt_q     <= '0;
         j_res_q      <= '0;
      end else if (smp_valid) begin
         pd_status[smp_chan]    <= status_d;
         pd_value[smp_chan]     <= value_d;
         raw_couple_q[smp_chan] <= smp_raw_couple;
         raw_ref_q[smp_chan]    <= smp_raw_ref;
         j_temp_q[smp_chan]     <= smp_junction_temp;
         j_volt_q[smp_chan]     <= smp_junction_volt;
         j_res_q[smp_chan]      <= smp_junction_res;
      end
   end

   // Checking helpers
   logic [1:0] upd_chan_q;
   logic       flag_bad;
   logic       lim_bad;
   wire logic  sel_toggle = pd_status[smp_chan][TCOD_BIT_TOGGLE];
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         upd_chan_q <= 2'h0;
      end else begin
         upd_chan_q <= smp_chan;
      end
   end
   always_comb begin
      flag_bad = 1'b0;
      lim_bad  = 1'b0;
      for (int k = 0; k < TCOD_CHANNELS; k++) begin
         if (pd_status[k][TCOD_BIT_INVALID] != (pd_status[k][TCOD_BIT_ABOVE] | pd_status[k][TCOD_BIT_BELOW])
             || pd_status[k][TCOD_BIT_VALIDITY] != pd_status[k][TCOD_BIT_INVALID]) begin
            flag_bad = 1'b1;
         end
         if (pd_status[k][TCOD_BIT_LIM1 +: 2] == TCOD_LIM_ILLEGAL
             || pd_status[k][TCOD_BIT_LIM2 +: 2] == TCOD_LIM_ILLEGAL) begin
            lim_bad = 1'b1;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_read(logic [15:0] idx, logic [7:0] sub);
      rd_only && obj_index == idx && obj_subindex == sub;
   endsequence
   sequence s_open_sample;
      smp_valid && smp_open;
   endsequence

   a_flag_consistency: assert property (!flag_bad)
      else $error("Invalid or validity flag disagrees with range flags");
   a_limit_codes: assert property (!lim_bad)
      else $error("Limit field holds an illegal code");
   a_toggle_flip: assert property (smp_valid |=> pd_status[upd_chan_q][TCOD_BIT_TOGGLE] != $past(sel_toggle))
      else $error("Update toggle did not invert on refresh");
   a_open_wire: assert property (s_open_sample |=> pd_status[upd_chan_q][TCOD_BIT_ABOVE]
                                 && pd_status[upd_chan_q][TCOD_BIT_INVALID])
      else $error("Open wire not shown as above range with invalid");
   a_below_flag: assert property (smp_valid |=> pd_status[upd_chan_q][TCOD_BIT_BELOW] == $past(smp_below))
      else $error("Below range flag does not follow the sample");
   a_image_together: assert property (smp_valid |=> pd_value[upd_chan_q] == $past(value_d)
                                      && pd_status[upd_chan_q] == $past(status_d))
      else $error("Value and status not refreshed together");
   a_read_answer: assert property (obj_rd |=> obj_ack ##1 !obj_ack || $past(obj_rd || obj_wr))
      else $error("Read not answered in one cycle");
   a_spacing_read: assert property (s_read(TCOD_IDX_PROFILE, TCOD_SUB_SPACING)
                                    |=> obj_ack && obj_rdata == {16'h0000, TCOD_SPACING})
      else $error("Channel spacing reads wrong");
   a_device_type: assert property (s_read(TCOD_IDX_DEV_TYPE, TCOD_SUB_MAX)
                                   |=> obj_rdata[15:0] == TCOD_COMM_PROFILE)
      else $error("Device type low half is not the profile number");
   a_serial_high: assert property (s_read(TCOD_IDX_IDENTITY, TCOD_SUB_SERIAL)
                                   |=> obj_rdata[31:16] == 16'h0000 && !obj_err)
      else $error("Serial number upper half not zero");
   a_checksum_follow: assert property (wr_thr1 && obj_wdata[15:0] != thr1_q[ch]
                                       |=> ##1 checksum_q != $past(checksum_q))
      else $error("Checksum did not follow a threshold change");

endmodule // tcod_object_dictionary
`default_nettype wire

// ==== tb/tcod_master_model.sv ====
/* Master model: one object access per call; expects an acknowledge one cycle after each request. */
`default_nettype none
module tcod_master_model (
   // Clock and object access
   input  wire logic        sys_clk,
   output var  logic        obj_rd       = 1'b0,
   output var  logic        obj_wr       = 1'b0,
   output var  logic [15:0] obj_index    = 16'h0000,
   output var  logic [7:0]  obj_subindex = 8'h00,
   output var  logic [31:0] obj_wdata    = 32'h0000_0000,
   input  wire logic [31:0] obj_rdata,
   input  wire logic        obj_ack,
   input  wire logic        obj_err
);
   timeunit 1ns / 1ps;
   task automatic access(input logic [56:0] req, output logic [32:0] rsp);
      @(posedge sys_clk);
      {obj_rd, obj_wr, obj_index, obj_subindex, obj_wdata} <= {~req[56], req};
      @(posedge sys_clk);
      {obj_rd, obj_wr, obj_index, obj_wdata} <= {2'b00, ~req[55:40], ~req[31:0]};
      @(posedge sys_clk);
      rsp = obj_ack ? {obj_err, obj_rdata} : 33'h1_FFFF_FFFF;
   endtask
endmodule // tcod_master_model
`default_nettype wire

// ==== tb/tcod_object_dictionary_tb.sv ====
/* Bench of the object dictionary; issues object accesses through the master model and checks the answers. */
`default_nettype none
module tcod_object_dictionary_tb import tcod_pkg::*; ();
   timeunit 1ns / 1ps;
   logic             sys_clk = 1'b0, nrst = 1'b0, smp_valid = 1'b0, smp_below = 1'b0, smp_above = 1'b0;
   logic             smp_open = 1'b0, obj_rd, obj_wr, obj_ack, obj_err;
   logic [1:0]       smp_chan = 2'h0;
   logic [7:0]       obj_subindex;
   logic [15:0]      obj_index, smp_rel_temp = 16'h0000, smp_junction_temp = 16'h0000;
   logic [31:0]      obj_wdata, obj_rdata;
   logic [3:0][15:0] pd_status, pd_value;
   int               error_cnt = 0, check_count = 0;
   always #12.5 sys_clk = ~sys_clk;
   tcod_object_dictionary u_tcod_object_dictionary (.*, .smp_raw_couple(32'h1234_5678), .smp_raw_ref(32'h0000_0ABC),
      .smp_junction_volt(16'hFF00), .smp_junction_res(16'h2710));
   tcod_master_model u_tcod_master_model (.*);
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) error_cnt++;
      if (seen !== exp) $display("Error at %0t: seen %h expected %h", $time, seen, exp);
   endtask
   task automatic acc(input logic [56:0] req, input logic [32:0] exp);
      logic [32:0] got;
      u_tcod_master_model.access(req, got);
      check(got, exp);
   endtask
   task automatic smp(input logic [1:0] c, input logic [15:0] t, j, input logic [2:0] f, input logic [31:0] e);
      @(posedge sys_clk);
      {smp_valid, smp_chan, smp_rel_temp, smp_junction_temp, smp_open, smp_above, smp_below} <= {1'b1, c, t, j, f};
      @(posedge sys_clk);
      smp_valid <= 1'b0;
      #1;
      check({1'b0, pd_status[c], pd_value[c]}, {1'b0, e});
   endtask
   task automatic t_ident();
      acc({1'b0, 16'hF000, 8'h01, 32'h0}, 33'h10);
      acc({1'b0, 16'h1000, 8'h00, 32'h0}, 33'h1389);
      acc({1'b0, 16'hF000, 8'h02, 32'h0}, 33'h4);
      acc({1'b0, 16'h1018, 8'h01, 32'h0}, 33'h0_0000_5A17);
      acc({1'b0, 16'h1018, 8'h03, 32'h0}, 33'h0_0001_0000);
      acc({1'b0, 16'h1018, 8'h04, 32'h0}, 33'h0);
      $display("Identity test done");
   endtask
   task automatic t_stream();
      smp(2'h2, 16'h0064, 16'h000A, 3'b001, 32'hC041_006E);
      acc({1'b1, 16'h7010, 8'h11, 32'h32}, 33'h0);
      acc({1'b1, 16'h8010, 8'h0C, 32'h2}, 33'h0);
      acc({1'b1, 16'h8010, 8'h13, 32'h78}, 33'h0);
      acc({1'b1, 16'h8010, 8'h07, 32'h1}, 33'h0);
      acc({1'b0, 16'h10F0, 8'h01, 32'h0}, 33'h7B);
      acc({1'b1, 16'h8010, 8'h0C, 32'h3}, 33'h1_0000_0000);
      acc({1'b0, 16'h8010, 8'h0C, 32'h0}, 33'h2);
      acc({1'b1, 16'h6010, 8'h11, 32'h5}, 33'h1_0000_0000);
      smp(2'h1, 16'h0064, 16'h03E7, 3'b100, 32'hC046_0096);
      smp(2'h1, 16'h0000, 16'h03E7, 3'b000, 32'h0008_0032);
      acc({1'b0, 16'h6010, 8'h11, 32'h0}, 33'h32);
      acc({1'b0, 16'h801E, 8'h01, 32'h0}, 33'h0_1234_5678);
      acc({1'b0, 16'h801E, 8'h03, 32'h0}, 33'h0_0000_03E7);
      acc({1'b0, 16'h801E, 8'h04, 32'h0}, 33'h0_0000_FF00);
      acc({1'b0, 16'h801E, 8'h05, 32'h0}, 33'h0_0000_2710);
      $display("Stream test done");
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      t_ident();
      t_stream();
      wrap_up();
   end
   initial begin
      #20000 error_cnt++;
      wrap_up();
   end
endmodule // tcod_object_dictionary_tb
`default_nettype wire
